// [design/bms_pkg.sv]
// constants and types shared by the boot mode selector
package bms_pkg;
   localparam int unsigned GPIO_COUNT    = 256;
   localparam int unsigned FIELD_W       = 8;
   localparam int unsigned NUM_SEL_PINS  = 3;
   localparam int unsigned EMU_WORDS     = 4;
   localparam int unsigned EMU_ADDR_W    = 2;

   // default boot-select pins, two family variants
   localparam logic [7:0] DFLT_PIN1_A    = 8'h18;  // gpio 24
   localparam logic [7:0] DFLT_PIN0_A    = 8'h20;  // gpio 32
   localparam logic [7:0] DFLT_PIN1_B    = 8'h48;  // gpio 72
   localparam logic [7:0] DFLT_PIN0_B    = 8'h54;  // gpio 84

   // pin map word layout
   localparam int unsigned MAP_PIN0_LSB  = 0;
   localparam int unsigned MAP_PIN1_LSB  = 8;
   localparam int unsigned MAP_PIN2_LSB  = 16;
   localparam int unsigned MAP_KEY_LSB   = 24;
   localparam logic [7:0] PIN_MAP_VALID_KEY = 8'h5A;
   localparam logic [7:0] PIN_DISABLED   = 8'hFF;

   // emulation copy word offsets
   localparam logic [1:0] EMU_MAP_ADDR   = 2'h0;
   localparam logic [1:0] EMU_DEF_LO_ADDR = 2'h1;
   localparam logic [1:0] EMU_DEF_HI_ADDR = 2'h2;

   // reset values
   localparam logic [31:0] MAP_RST       = 32'h00000000;
   localparam logic [63:0] DEF_RST       = 64'h0000000000000000;
   localparam logic [31:0] EMU_WORD_RST  = 32'h00000000;

   // default boot table entries
   localparam logic [7:0] MODE_PARALLEL  = 8'h00;
   localparam logic [7:0] MODE_SCI_WAIT  = 8'h01;
   localparam logic [7:0] MODE_CAN       = 8'h02;
   localparam logic [7:0] MODE_FLASH     = 8'h03;

   typedef enum logic {
      BMS_BOOT_STANDALONE,
      BMS_BOOT_EMULATION
   } bms_boot_kind_t;

   typedef struct packed {
      logic           done;
      bms_boot_kind_t kind;
      logic           custom_map;
      logic [2:0]     index;
      logic [7:0]     mode;
   } bms_result_t;

   localparam bms_result_t RESULT_RST = '{done: 1'b0, kind: BMS_BOOT_STANDALONE,
                                          custom_map: 1'b0, index: 3'h0, mode: 8'h00};
endpackage

// [design/bms_emu_mem.sv]
// rewritable copy of the boot configuration words used by emulation boot
`timescale 1ns/100ps
module bms_emu_mem
(
   input  wire logic        i_sys_clk,   // system clock
   input  wire logic        i_srst,      // sync reset, active high
   input  wire logic        i_wr_en,     // write strobe
   input  wire logic [1:0]  i_wr_addr,   // write word address
   input  wire logic [31:0] i_wr_data,   // write data
   input  wire logic [1:0]  i_rd_addr,   // read word address
   output logic      [31:0] o_rd_data    // registered read data, one cycle late
);
   logic [31:0] mem_reg [bms_pkg::EMU_WORDS];

   // -------------------------------------------------
   // storage, no write limit
   // -------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < bms_pkg::EMU_WORDS; g++)
      begin : g_word
         always_ff @(posedge i_sys_clk)
         begin
            if (i_srst)
               mem_reg[g] <= bms_pkg::EMU_WORD_RST;
            else if (i_wr_en && (i_wr_addr == 2'(g)))
               mem_reg[g] <= i_wr_data;
         end
      end
   endgenerate

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         o_rd_data <= bms_pkg::EMU_WORD_RST;
      else
         o_rd_data <= mem_reg[i_rd_addr];
   end
endmodule

// [design/bms_boot_mode_selector.sv]
// boot mode selector: emulation/standalone decision and boot-select pin decode
//
// Summary of operation
// - after initialisation pick emulation boot if debugger-connect bit set, else standalone
// - legacy families judge debugger presence from the test reset pin instead
// - emulation boot reads rewritable RAM copies shaped like the programmed words
// - every reset reruns the sequence; path depends on debugger and configuration
// - standalone boot samples boot-select pins after initialisation to choose mode
// - each boot-select pin maps to a user map field; without a valid map pins 0 and 1 use a default gpio and pin 2 is disabled
// - default pins: gpio 24 is select pin 1, gpio 32 is pin 0
// - default decode: 00 parallel, 01 serial/wait, 10 CAN, 11 flash
// - pin pair strap picks default pair 24/32 or 72/84
// - default modes work with nothing programmed
// - user pin map valid only when top byte is 0x5A, else defaults
// - pin 0 is index lsb, pin 2 msb; field 0xFF disables that pin
`timescale 1ns/100ps
module bms_boot_mode_selector
(
   input  wire logic        i_sys_clk,        // system clock, 100 MHz
   input  wire logic        i_srst,           // sync reset, active high
   input  wire logic        i_init_done,      // device initialisation complete, level
   input  wire logic        i_debugger_connect_bit, // jtag debugger-connect bit
   input  wire logic        i_trst_n,         // jtag test reset pin
   input  wire logic        i_legacy_family,  // strap: judge debugger by test reset pin
   input  wire logic        i_alt_pin_pair,   // strap: default pins 72/84 instead of 24/32
   input  wire logic [255:0] i_gpio,          // gpio pin levels
   input  wire logic [31:0] i_otp_pin_map,    // programmed boot_pin_map_word
   input  wire logic [63:0] i_otp_boot_def,   // programmed boot_definition_table
   input  wire logic        i_emu_wr_en,      // emulation copy write strobe
   input  wire logic [1:0]  i_emu_wr_addr,    // emulation copy word address
   input  wire logic [31:0] i_emu_wr_data,    // emulation copy write data
   output bms_pkg::bms_result_t o_result      // registered boot decision
);
   typedef enum logic [2:0] {
      ST_WAIT_INIT,
      ST_DECIDE,
      ST_EMU_MAP,
      ST_EMU_LO,
      ST_EMU_HI,
      ST_EMU_END,
      ST_SAMPLE,
      ST_DONE
   } bms_state_t;

   bms_state_t   state_reg;
   bms_state_t   state_next;
   logic [255:0] gpio_meta_reg;
   logic [255:0] gpio_sync_reg;
   logic [1:0]   dbg_meta_reg;
   logic [1:0]   dbg_sync_reg;
   logic [1:0]   strap_meta_reg;
   logic [1:0]   strap_sync_reg;
   logic         emu_reg;
   logic [31:0]  map_reg;
   logic [63:0]  def_reg;
   logic [1:0]   emu_rd_addr;
   logic [31:0]  emu_rd_data;
   logic         map_valid;
   logic [7:0]   pin_field [bms_pkg::NUM_SEL_PINS];
   logic [2:0]   sel_index;
   logic [7:0]   sel_mode;
   logic         attached;

   // -------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         gpio_meta_reg <= '0;
         gpio_sync_reg <= '0;
      end
      else
      begin
         gpio_meta_reg <= i_gpio;
         gpio_sync_reg <= gpio_meta_reg;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         dbg_meta_reg   <= 2'h0;
         dbg_sync_reg   <= 2'h0;
         strap_meta_reg <= 2'h0;
         strap_sync_reg <= 2'h0;
      end
      else
      begin
         dbg_meta_reg   <= {i_trst_n, i_debugger_connect_bit};
         dbg_sync_reg   <= dbg_meta_reg;
         // straps are board pins as well, so they get the same two stages
         strap_meta_reg <= {i_alt_pin_pair, i_legacy_family};
         strap_sync_reg <= strap_meta_reg;
      end
   end

   // test reset pin is held low by the board when no probe drives it
   assign attached = strap_sync_reg[0] ? dbg_sync_reg[1] : dbg_sync_reg[0];

   // -------------------------------------------------
   // emulation configuration copy
   // -------------------------------------------------
   bms_emu_mem u_emu_mem
   (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .i_wr_en   (i_emu_wr_en),
      .i_wr_addr (i_emu_wr_addr),
      .i_wr_data (i_emu_wr_data),
      .i_rd_addr (emu_rd_addr),
      .o_rd_data (emu_rd_data)
   );

   always_comb
   begin
      unique case (state_reg)
         ST_EMU_LO : emu_rd_addr = bms_pkg::EMU_DEF_LO_ADDR;
         ST_EMU_HI : emu_rd_addr = bms_pkg::EMU_DEF_HI_ADDR;
         default   : emu_rd_addr = bms_pkg::EMU_MAP_ADDR;
      endcase
   end

   // -------------------------------------------------
   // sequence
   // -------------------------------------------------
   always_comb
   begin
      unique case (state_reg)
         ST_WAIT_INIT : state_next = i_init_done ? ST_DECIDE : ST_WAIT_INIT;
         ST_DECIDE    : state_next = attached ? ST_EMU_MAP : ST_SAMPLE;
         ST_EMU_MAP   : state_next = ST_EMU_LO;
         ST_EMU_LO    : state_next = ST_EMU_HI;
         ST_EMU_HI    : state_next = ST_EMU_END;
         ST_EMU_END   : state_next = ST_SAMPLE;
         ST_SAMPLE    : state_next = ST_DONE;
         ST_DONE      : state_next = ST_DONE;
      endcase
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         state_reg <= ST_WAIT_INIT;
      else
         state_reg <= state_next;
   end

   // configuration source: programmed words or the emulation copy
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         emu_reg <= 1'b0;
         map_reg <= bms_pkg::MAP_RST;
         def_reg <= bms_pkg::DEF_RST;
      end
      else
      begin
         unique case (state_reg)
            ST_DECIDE :
            begin
               emu_reg <= attached;
               map_reg <= i_otp_pin_map;
               def_reg <= i_otp_boot_def;
            end
            ST_EMU_LO  : map_reg <= emu_rd_data;
            ST_EMU_HI  : def_reg[31:0] <= emu_rd_data;
            ST_EMU_END : def_reg[63:32] <= emu_rd_data;
            default    : ;
         endcase
      end
   end

   // -------------------------------------------------
   // pin decode
   // -------------------------------------------------
   assign map_valid = (map_reg[bms_pkg::MAP_KEY_LSB +: 8] == bms_pkg::PIN_MAP_VALID_KEY);

   always_comb
   begin
      if (map_valid)
      begin
         pin_field[0] = map_reg[bms_pkg::MAP_PIN0_LSB +: 8];
         pin_field[1] = map_reg[bms_pkg::MAP_PIN1_LSB +: 8];
         pin_field[2] = map_reg[bms_pkg::MAP_PIN2_LSB +: 8];
      end
      else
      begin
         pin_field[0] = strap_sync_reg[1] ? bms_pkg::DFLT_PIN0_B : bms_pkg::DFLT_PIN0_A;
         pin_field[1] = strap_sync_reg[1] ? bms_pkg::DFLT_PIN1_B : bms_pkg::DFLT_PIN1_A;
         pin_field[2] = bms_pkg::PIN_DISABLED;
      end
   end

   genvar p;
   generate
      for (p = 0; p < bms_pkg::NUM_SEL_PINS; p++)
      begin : g_sel
         // a disabled pin reads as zero but keeps its positional weight
         assign sel_index[p] = (pin_field[p] != bms_pkg::PIN_DISABLED)
                               && gpio_sync_reg[pin_field[p]];
      end
   endgenerate

   always_comb
   begin
      if (map_valid)
         sel_mode = def_reg[{sel_index, 3'h0} +: 8];
      else
      begin
         // built-in table needs nothing programmed
         unique case (sel_index[1:0])
            2'h0 : sel_mode = bms_pkg::MODE_PARALLEL;
            2'h1 : sel_mode = bms_pkg::MODE_SCI_WAIT;
            2'h2 : sel_mode = bms_pkg::MODE_CAN;
            2'h3 : sel_mode = bms_pkg::MODE_FLASH;
         endcase
      end
   end

   // -------------------------------------------------
   // result, captured once per reset
   // -------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         o_result <= bms_pkg::RESULT_RST;
      else if (state_reg == ST_SAMPLE)
      begin
         o_result.done       <= 1'b1;
         o_result.kind       <= emu_reg ? bms_pkg::BMS_BOOT_EMULATION
                                        : bms_pkg::BMS_BOOT_STANDALONE;
         o_result.custom_map <= map_valid;
         o_result.index      <= sel_index;
         o_result.mode       <= sel_mode;
      end
   end
endmodule

// [dv/bms_board_model.sv]
// board straps and debug probe seen by the boot mode selector
`timescale 1ns/100ps
module bms_board_model
(
   input  wire logic         i_sys_clk, // system clock
   input  wire logic         i_probe,   // probe attached
   input  wire logic         i_legacy,  // legacy family part
   input  wire logic [23:0]  i_pins,    // gpio per select pin, FF none
   input  wire logic [2:0]   i_lvl,     // strap level per select pin
   output logic              o_debugger_connect_bit, // debugger connect bit
   output logic              o_trst_n,  // test reset pin
   output logic      [255:0] o_gpio     // gpio levels
);
   logic [255:0] noise_reg = {8{32'hC3A5_96E1}};

   // loose gpios toggle so a wrong pin choice cannot match by luck
   always_ff @(posedge i_sys_clk)
      noise_reg <= ~noise_reg;

   always_comb
   begin
      o_gpio = noise_reg;
      for (int p = 0; p < 3; p++)
         if (i_pins[8*p +: 8] != 8'hFF)
            o_gpio[i_pins[8*p +: 8]] = i_lvl[p];
   end

   // legacy parts carry no connect bit, so it shows the wrong answer there
   assign o_debugger_connect_bit = i_legacy ? ~i_probe : i_probe;
   assign o_trst_n = i_legacy ? i_probe : noise_reg[0];
endmodule

// [dv/bms_boot_mode_selector_sva.sv]
// port assertions for the boot mode selector
`timescale 1ns/100ps
module bms_boot_mode_selector_sva
(
   input wire logic                i_sys_clk,              // system clock
   input wire logic                i_srst,                 // sync reset
   input wire logic                i_init_done,            // init complete
   input wire logic                i_debugger_connect_bit, // connect bit
   input wire logic                i_trst_n,               // test reset pin
   input wire logic                i_legacy_family,        // legacy strap
   input wire logic                i_alt_pin_pair,         // pin pair strap
   input wire logic [255:0]        i_gpio,                 // gpio levels
   input wire logic [31:0]         i_otp_pin_map,          // programmed map
   input wire logic [63:0]         i_otp_boot_def,         // programmed table
   input wire bms_pkg::bms_result_t o_result                // boot decision
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);

   AST_HOLD: assert property (o_result.done && $past(o_result.done) |-> $stable(o_result))
      else $error("decision moved before reset");
   AST_INIT: assert property ($rose(o_result.done) |-> $past(i_init_done, 3))
      else $error("decision without initialisation");
   AST_DBG: assert property ($rose(o_result.done) && !i_legacy_family |->
      o_result.kind == bms_pkg::bms_boot_kind_t'(i_debugger_connect_bit))
      else $error("boot kind disagrees with connect bit");
   AST_TRST: assert property ($rose(o_result.done) && i_legacy_family |->
      o_result.kind == bms_pkg::bms_boot_kind_t'(i_trst_n))
      else $error("boot kind disagrees with test reset pin");
   AST_DMODE: assert property ($rose(o_result.done) && !o_result.custom_map |->
      o_result.mode == {5'h00, o_result.index})
      else $error("default mode wrong");
   AST_NOPIN2: assert property ($rose(o_result.done) && !o_result.custom_map |->
      !o_result.index[2])
      else $error("pin 2 used without key");
   AST_DPINS: assert property ($rose(o_result.done) && !o_result.custom_map |->
      o_result.index[1:0] == (i_alt_pin_pair ? {i_gpio[72], i_gpio[84]}
                                              : {i_gpio[24], i_gpio[32]}))
      else $error("default pins misread");
   AST_KEY: assert property ($rose(o_result.done) && !o_result.kind |->
      o_result.custom_map == (i_otp_pin_map[31:24] == 8'h5A))
      else $error("key check wrong");
   AST_TABLE: assert property ($rose(o_result.done) && !o_result.kind && o_result.custom_map |->
      o_result.mode == i_otp_boot_def[{o_result.index, 3'h0} +: 8])
      else $error("table entry wrong");

   COV_SA: cover property ($rose(o_result.done) && !o_result.kind);
   COV_EMU: cover property ($rose(o_result.done) && o_result.kind);
   COV_MAP: cover property ($rose(o_result.done) && o_result.custom_map);
endmodule

bind bms_boot_mode_selector bms_boot_mode_selector_sva bms_boot_mode_selector_sva_i (
   .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_init_done(i_init_done),
   .i_debugger_connect_bit(i_debugger_connect_bit), .i_trst_n(i_trst_n),
   .i_legacy_family(i_legacy_family), .i_alt_pin_pair(i_alt_pin_pair), .i_gpio(i_gpio),
   .i_otp_pin_map(i_otp_pin_map), .i_otp_boot_def(i_otp_boot_def), .o_result(o_result));

// [dv/bms_boot_mode_selector_test.sv]
// self-checking bench for the boot mode selector
`timescale 1ns/100ps
module bms_boot_mode_selector_test;
   localparam logic [7:0] DM [4] = '{bms_pkg::MODE_PARALLEL, bms_pkg::MODE_SCI_WAIT,
                                     bms_pkg::MODE_CAN, bms_pkg::MODE_FLASH};
   logic                 i_sys_clk = 1'b0;
   logic                 i_srst = 1'b1;
   logic                 i_init_done = 1'b0;
   logic                 probe = 1'b0;
   logic                 i_legacy_family = 1'b0;
   logic                 i_alt_pin_pair = 1'b0;
   logic [2:0]           lvl = 3'h0;
   logic [31:0]          cmap = 32'h0;
   logic [31:0]          i_otp_pin_map = 32'h0;
   logic [63:0]          i_otp_boot_def = 64'h0;
   logic                 i_emu_wr_en = 1'b0;
   logic [1:0]           i_emu_wr_addr = 2'h0;
   logic [31:0]          i_emu_wr_data = 32'h0;
   logic [23:0]          pins;
   logic                 connect_bit;
   logic                 trst_n;
   logic                 prev_done;
   logic [255:0]         gpio;
   logic [7:0]           f [3];
   bms_pkg::bms_result_t o_result;
   bms_pkg::bms_result_t exp_q [$];
   int                   err_count = 0;
   int                   n_tests = 0;

   always #5 i_sys_clk = ~i_sys_clk;

   assign pins = (cmap[31:24] == bms_pkg::PIN_MAP_VALID_KEY) ? cmap[23:0] :
                 {8'hFF, i_alt_pin_pair ? {bms_pkg::DFLT_PIN1_B, bms_pkg::DFLT_PIN0_B}
                                        : {bms_pkg::DFLT_PIN1_A, bms_pkg::DFLT_PIN0_A}};

   bms_board_model bms_board_model_i (.i_sys_clk(i_sys_clk), .i_probe(probe),
      .i_legacy(i_legacy_family), .i_pins(pins), .i_lvl(lvl),
      .o_debugger_connect_bit(connect_bit),
      .o_trst_n(trst_n), .o_gpio(gpio));

   bms_boot_mode_selector bms_boot_mode_selector_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
      .i_init_done(i_init_done), .i_debugger_connect_bit(connect_bit), .i_trst_n(trst_n),
      .i_legacy_family(i_legacy_family), .i_alt_pin_pair(i_alt_pin_pair), .i_gpio(gpio),
      .i_otp_pin_map(i_otp_pin_map), .i_otp_boot_def(i_otp_boot_def),
      .i_emu_wr_en(i_emu_wr_en), .i_emu_wr_addr(i_emu_wr_addr),
      .i_emu_wr_data(i_emu_wr_data), .o_result(o_result));

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [13:0] seen, input logic [13:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // emulation runs load the copy words and leave an invalid key in the programmed words
   task automatic run(input logic pr, input logic lg, input logic [31:0] m,
                      input logic [63:0] d, input logic [2:0] l);
      bms_pkg::bms_result_t e;
      logic                 v;
      v = (m[31:24] == bms_pkg::PIN_MAP_VALID_KEY);
      e = bms_pkg::RESULT_RST;
      e.done = 1'b1;
      e.kind = pr ? bms_pkg::BMS_BOOT_EMULATION : bms_pkg::BMS_BOOT_STANDALONE;
      e.custom_map = v;
      for (int p = 0; p < 3; p++)
         e.index[p] = v ? (m[8*p +: 8] != bms_pkg::PIN_DISABLED) && l[p] : (p < 2) && l[p];
      e.mode = v ? d[{e.index, 3'h0} +: 8] : DM[l[1:0]];
      @(posedge i_sys_clk);
      i_srst <= 1'b1;
      i_init_done <= 1'b0;
      probe <= pr;
      i_legacy_family <= lg;
      lvl <= l;
      cmap <= m;
      i_otp_pin_map <= pr ? {8'h00, ~m[23:0]} : m;
      i_otp_boot_def <= pr ? ~d : d;
      repeat (2) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      check(o_result, bms_pkg::RESULT_RST);
      for (int k = 0; k < 3; k++)
      begin
         i_emu_wr_en <= pr;
         i_emu_wr_addr <= 2'(k);
         i_emu_wr_data <= (k == 0) ? m : (k == 1) ? d[31:0] : d[63:32];
         @(posedge i_sys_clk);
      end
      i_emu_wr_en <= 1'b0;
      i_init_done <= 1'b1;
      exp_q.push_back(e);
      for (int k = 0; k < 20 && o_result.done !== 1'b1; k++)
         @(posedge i_sys_clk);
      if (o_result.done !== 1'b1)
      begin
         err_count++;
         end_sim();
      end
      lvl <= ~l;
      i_otp_pin_map <= ~i_otp_pin_map;
      repeat (5) @(posedge i_sys_clk);
      check(o_result, e);
   endtask

   always @(posedge i_sys_clk)
   begin
      prev_done <= o_result.done;
      if (o_result.done === 1'b1 && prev_done !== 1'b1)
      begin
         // a decision with no note behind it is always a mismatch
         if (exp_q.size() > 0)
            check(o_result, exp_q.pop_front());
         else
            check(o_result, bms_pkg::RESULT_RST);
      end
   end

   initial
   begin
      void'($urandom(32'h5ADD));
      for (int a = 0; a < 8; a++)
      begin
         i_alt_pin_pair <= a[2];
         run(1'b0, 1'b0, bms_pkg::MAP_RST, bms_pkg::DEF_RST, {1'($urandom), a[1:0]});
      end
      for (int j = 0; j < 16; j++)
      begin
         for (int k = 0; k < 3; k++)
            f[k] = ($urandom_range(0, 3) == 0) ? bms_pkg::PIN_DISABLED
                                                : 8'(80 * k + $urandom_range(0, 79));
         i_alt_pin_pair <= j[3];
         run(j[0], j[1], {j[2] ? 8'h00 : bms_pkg::PIN_MAP_VALID_KEY, f[2], f[1], f[0]},
             {$urandom, $urandom}, 3'($urandom));
      end
      end_sim();
   end
endmodule
